// ---- rtl/hsc_top.sv ----
// Receive status stack and transmit byte-count pacing with APB registers
//
// Implementation choices: register access over APB and the register offsets.
`timescale 1ns/1ps
module hsc_top #(
	parameter int LEN_W = 16
) (
	// Clock and reset
	input  wire logic        ref_clk,
	input  wire logic        rst_n,
	input  wire logic        clk_en,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Receiver packet end and status
	input  wire logic        rx_pkt_end,
	input  wire logic        rx_overrun,
	input  wire logic [15:0] rx_byte_cnt,
	input  wire logic [4:0]  rx_frame_err,
	input  wire logic [2:0]  rx_addr_id,
	input  wire logic [2:0]  rx_residue,
	input  wire logic        rx_last_byte_out,
	input  wire logic        rx_dma_raw,
	output logic             rx_blocked,
	output logic             rx_hunt,
	output logic             rx_dma_request,
	// Transmit FIFO side
	input  wire logic        tx_fifo_wr,
	input  wire logic [4:0]  tx_fifo_level,
	input  wire logic        tx_fifo_full,
	input  wire logic        tx_fifo_empty,
	input  wire logic        tx_last_to_shift,
	output logic             tx_dma_request,
	output logic             tx_start_flag,
	output logic             tx_last_byte_mark,
	// Interrupt pin
	output logic             link_ctrl_irq_out
);
	localparam int CW = $clog2(hsc_pkg::STACK_DEPTH+1);

	// Address decode helper
	function automatic logic hsc_hit(input logic [7:0] a, input logic [7:0] off);
		hsc_hit = (a == off);
	endfunction : hsc_hit

	// Register state
	logic [31:0]          prdata_q;
	logic                 pready_q;
	logic                 pslverr_q;
	logic [LEN_W-1:0]     len_q;
	logic [LEN_W-1:0]     tbc_q;
	logic [LEN_W-1:0]     tbc_d;
	logic [7:0]           en_q;
	logic [4:0]           thr_q;
	logic [3:0]           clr_q;
	logic [CW-1:0]        drained_q;
	logic                 blocked_q;
	logic                 hunt_q;
	logic                 eop_hold_q;
	logic                 rxdma_q;
	logic                 sent_q;
	logic                 irq_q;
	logic                 fill_hold_q;
	logic                 fill_hold_d;
	logic                 txdma_q;
	logic                 start_q;
	logic                 mark_q;
	hsc_pkg::hsc_tx_e     tx_st_q;
	hsc_pkg::hsc_tx_e     tx_st_d;

	// Bus phases
	logic                 setup_rd;
	logic                 acc_wr;
	logic                 mapped;
	logic [31:0]          rdata;
	// Stack signals
	logic [hsc_pkg::ENTRY_W-1:0] entry_in;
	logic [hsc_pkg::ENTRY_W-1:0] head;
	logic [CW-1:0]        stk_cnt;
	logic                 stk_full;
	logic                 stk_empty;
	logic                 push;
	logic                 pop;
	logic                 vis;
	logic [5:0]           err_all;
	// Head fields
	logic [15:0]          h_bc;
	logic [5:0]           h_err;
	logic [2:0]           h_adr;
	logic [2:0]           h_res;
	logic [7:0]           isr_bits;
	// Access strobes and next-state signals
	logic                 rd_lo;
	logic                 rd_hi;
	logic                 rd_fs;
	logic                 rd_isr;
	logic                 rd_res;
	logic                 wr_len;
	logic                 tx_wr_ok;
	logic                 open_q;
	logic                 rd_vis_q;
	logic                 acc_rd;
	logic                 head_live;
	logic                 drain_inc;
	logic [CW-1:0]        drained_d;
	logic                 blocked_d;
	logic                 eop_hold_d;
	logic                 sent_d;
	logic [3:0]           clr_d;
	logic                 load_now;
	logic                 reload;
	logic                 wr_en;
	logic                 wr_thr;

	// Status queue, oldest entry at the head
	hsc_stack #(
		.W     (hsc_pkg::ENTRY_W),
		.DEPTH (hsc_pkg::STACK_DEPTH)
	) u_stack (
		.ref_clk (ref_clk),
		.rst_n   (rst_n),
		.clk_en  (clk_en),
		.push    (push),
		.pop     (pop),
		.din     (entry_in),
		.dout    (head),
		.count   (stk_cnt),
		.full    (stk_full),
		.empty   (stk_empty)
	);

	// Bus phases: answer one cycle into access, effect at completion
	assign setup_rd = psel && penable && !pready_q;
	assign acc_wr   = psel && penable && pready_q && pwrite && !pslverr_q;
	assign acc_rd   = psel && penable && pready_q && !pwrite && !pslverr_q;
	assign mapped   = hsc_hit(paddr, hsc_pkg::OFF_RBC_LO) || hsc_hit(paddr, hsc_pkg::OFF_RBC_HI)
	               || hsc_hit(paddr, hsc_pkg::OFF_FRAME_ST) || hsc_hit(paddr, hsc_pkg::OFF_INT_SRC)
	               || hsc_hit(paddr, hsc_pkg::OFF_RESIDUE) || hsc_hit(paddr, hsc_pkg::OFF_TX_LEN)
	               || hsc_hit(paddr, hsc_pkg::OFF_INT_EN) || hsc_hit(paddr, hsc_pkg::OFF_TX_THR)
	               || hsc_hit(paddr, hsc_pkg::OFF_STATUS);

	// Access strobes
	assign rd_lo  = acc_rd && hsc_hit(paddr, hsc_pkg::OFF_RBC_LO);
	assign rd_hi  = acc_rd && hsc_hit(paddr, hsc_pkg::OFF_RBC_HI);
	assign rd_fs  = acc_rd && hsc_hit(paddr, hsc_pkg::OFF_FRAME_ST);
	assign rd_isr = acc_rd && hsc_hit(paddr, hsc_pkg::OFF_INT_SRC);
	assign rd_res = acc_rd && hsc_hit(paddr, hsc_pkg::OFF_RESIDUE);
	assign wr_len = acc_wr && hsc_hit(paddr, hsc_pkg::OFF_TX_LEN);
	assign wr_en  = acc_wr && hsc_hit(paddr, hsc_pkg::OFF_INT_EN);
	assign wr_thr = acc_wr && hsc_hit(paddr, hsc_pkg::OFF_TX_THR);

	// Incoming entry and head fields
	assign err_all  = {rx_overrun, rx_frame_err};
	assign entry_in = {rx_residue, rx_addr_id, err_all, rx_byte_cnt};
	assign push     = rx_pkt_end && !blocked_q;
	assign pop      = rd_lo && rd_vis_q;
	assign h_bc     = head[hsc_pkg::ENT_BC_LSB +: 16];
	assign h_err    = head[hsc_pkg::ENT_ERR_LSB +: hsc_pkg::ERR_W];
	assign h_adr    = head[hsc_pkg::ENT_ADR_LSB +: 3];
	assign h_res    = head[hsc_pkg::ENT_RES_LSB +: 3];
	assign vis      = (drained_q != '0);

	// Interrupt source, one read clears it all
	assign head_live = vis && !clr_q[hsc_pkg::CLR_ISR];
	assign isr_bits  = {2'b00, head_live && (h_err != '0), sent_q, head_live && (h_err == '0),
	                    (head_live ? h_adr : hsc_pkg::ADR_NO_PACKET)};

	// Read data select
	always_comb
	begin
		rdata = 32'h0000_0000;
		case (paddr)
			hsc_pkg::OFF_RBC_LO:   rdata[7:0] = vis ? h_bc[7:0] : 8'h00;
			hsc_pkg::OFF_RBC_HI:   rdata[7:0] = (vis && !clr_q[hsc_pkg::CLR_HI]) ? h_bc[15:8] : 8'h00;
			hsc_pkg::OFF_FRAME_ST: rdata[5:0] = (vis && !clr_q[hsc_pkg::CLR_FS]) ? h_err : 6'h00;
			hsc_pkg::OFF_INT_SRC:  rdata[7:0] = isr_bits;
			hsc_pkg::OFF_RESIDUE:  rdata[2:0] = (vis && !clr_q[hsc_pkg::CLR_RES]) ? h_res : 3'h0;
			hsc_pkg::OFF_TX_LEN:   rdata[LEN_W-1:0] = len_q;
			hsc_pkg::OFF_INT_EN:   rdata[7:0] = en_q;
			hsc_pkg::OFF_TX_THR:   rdata[4:0] = thr_q;
			hsc_pkg::OFF_STATUS:   rdata[7:0] = {stk_empty, stk_full, tx_st_q, stk_cnt, blocked_q};
			default:               rdata = 32'h0000_0000;
		endcase
	end

	// Bus answer and captured read data
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q  <= 32'h0000_0000;
			rd_vis_q  <= 1'b0;
		end
		else if (clk_en)
		begin
			pready_q  <= setup_rd;
			pslverr_q <= setup_rd && !mapped;
			if (setup_rd)
			begin
				prdata_q <= pwrite ? 32'h0000_0000 : rdata;
				rd_vis_q <= vis;
			end
		end
	end

	// Configuration registers
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			len_q <= LEN_W'(hsc_pkg::RST_TX_LEN);
			en_q  <= hsc_pkg::RST_INT_EN;
			thr_q <= hsc_pkg::RST_TX_THR;
		end
		else if (clk_en)
		begin
			if (wr_len)
				len_q <= pwdata[LEN_W-1:0];
			if (wr_en)
				en_q <= pwdata[7:0];
			if (wr_thr)
				thr_q <= pwdata[4:0];
		end
	end

	// Receive next state; only fields the read saw are cleared
	assign drain_inc  = rx_last_byte_out && (drained_q != stk_cnt);
	assign drained_d  = drained_q + CW'(drain_inc) - CW'(pop);
	assign blocked_d  = (blocked_q && !pop) || (push && !pop && (stk_cnt == CW'(hsc_pkg::STACK_DEPTH - 1)));
	assign eop_hold_d = rx_last_byte_out || (eop_hold_q && !rd_lo);
	assign clr_d      = pop ? 4'h0 : (clr_q | ({rd_res, rd_isr, rd_fs, rd_hi} & {4{rd_vis_q}}));
	assign sent_d     = tx_last_to_shift || (sent_q && !(rd_isr && prdata_q[hsc_pkg::ISR_VALID_TX]));

	// Receive state registers
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			drained_q  <= '0;
			clr_q      <= 4'h0;
			blocked_q  <= 1'b0;
			hunt_q     <= 1'b0;
			eop_hold_q <= 1'b0;
			rxdma_q    <= 1'b0;
			sent_q     <= 1'b0;
			irq_q      <= 1'b0;
		end
		else if (clk_en)
		begin
			drained_q  <= drained_d;
			clr_q      <= clr_d;
			blocked_q  <= blocked_d;
			hunt_q     <= blocked_q && pop;
			eop_hold_q <= eop_hold_d;
			rxdma_q    <= rx_dma_raw && !eop_hold_d;
			sent_q     <= sent_d;
			irq_q      <= |(en_q[7:3] & isr_bits[7:3]);
		end
	end

	// Transmit byte counter next value
	assign load_now    = wr_len && tx_fifo_empty && !open_q;
	assign reload      = tx_last_to_shift;
	assign tx_wr_ok    = tx_fifo_wr && (tbc_q != '0);
	assign tbc_d       = load_now ? pwdata[LEN_W-1:0]
	                   : (reload ? len_q : (tx_wr_ok ? tbc_q - 1'b1 : tbc_q));
	assign fill_hold_d = tx_fifo_full || (fill_hold_q && (tx_fifo_level > thr_q));

	// Transmit packet phase
	always_comb
	begin
		tx_st_d = tx_st_q;
		case (tx_st_q)
			hsc_pkg::TX_IDLE:
				if (tbc_d != '0)
					tx_st_d = hsc_pkg::TX_FILL;
			hsc_pkg::TX_FILL:
				if (tbc_d == '0)
					tx_st_d = hsc_pkg::TX_DRAIN;
			hsc_pkg::TX_DRAIN:
				if (reload)
					tx_st_d = (len_q != '0) ? hsc_pkg::TX_FILL : hsc_pkg::TX_IDLE;
			default: tx_st_d = hsc_pkg::TX_IDLE;
		endcase
	end

	// Transmit state registers
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			tbc_q       <= LEN_W'(hsc_pkg::RST_TX_LEN);
			fill_hold_q <= 1'b0;
			tx_st_q     <= hsc_pkg::TX_IDLE;
			txdma_q     <= 1'b0;
			start_q     <= 1'b0;
			mark_q      <= 1'b0;
			open_q      <= 1'b0;
		end
		else if (clk_en)
		begin
			tbc_q       <= tbc_d;
			fill_hold_q <= fill_hold_d;
			tx_st_q     <= tx_st_d;
			txdma_q     <= (tbc_d != '0) && !fill_hold_d;
			start_q     <= tx_fifo_wr && !open_q;
			mark_q      <= tx_wr_ok && (tbc_q == LEN_W'(1));
			open_q      <= (open_q || tx_fifo_wr) && !tx_last_to_shift;
		end
	end

	// Outputs straight from flip-flops
	assign prdata            = prdata_q;
	assign pready            = pready_q;
	assign pslverr           = pslverr_q;
	assign rx_blocked        = blocked_q;
	assign rx_hunt           = hunt_q;
	assign rx_dma_request    = rxdma_q;
	assign tx_dma_request    = txdma_q;
	assign tx_start_flag     = start_q;
	assign tx_last_byte_mark = mark_q;
	assign link_ctrl_irq_out = irq_q;
endmodule : hsc_top

// ---- rtl/hsc_pkg.sv ----
// Shared constants for receive status stacking and transmit byte-count pacing
package hsc_pkg;
	// Register byte offsets on APB
	localparam logic [7:0] OFF_RBC_LO   = 8'h00;
	localparam logic [7:0] OFF_RBC_HI   = 8'h04;
	localparam logic [7:0] OFF_FRAME_ST = 8'h08;
	localparam logic [7:0] OFF_INT_SRC  = 8'h0C;
	localparam logic [7:0] OFF_RESIDUE  = 8'h10;
	localparam logic [7:0] OFF_TX_LEN   = 8'h14;
	localparam logic [7:0] OFF_INT_EN   = 8'h18;
	localparam logic [7:0] OFF_TX_THR   = 8'h1C;
	localparam logic [7:0] OFF_STATUS   = 8'h20;

	// Sizes
	localparam int STACK_DEPTH = 4;
	localparam int TX_FIFO_DEPTH = 16;
	localparam int ERR_W = 6;
	localparam int ENTRY_W = 28;

	// Stack entry field positions
	localparam int ENT_BC_LSB  = 0;
	localparam int ENT_ERR_LSB = 16;
	localparam int ENT_ADR_LSB = 22;
	localparam int ENT_RES_LSB = 25;

	// Frame status error bit positions
	localparam int ERR_ABORT   = 0;
	localparam int ERR_NONINT  = 1;
	localparam int ERR_CRC     = 2;
	localparam int ERR_SHORT   = 3;
	localparam int ERR_LONG    = 4;
	localparam int ERR_OVERRUN = 5;

	// Interrupt source bit positions
	localparam int ISR_VALID_RX = 3;
	localparam int ISR_VALID_TX = 4;
	localparam int ISR_FS_ERR   = 5;

	// Address detector identity codes
	localparam logic [2:0] ADR_NO_PACKET = 3'h6;

	// Read-clear flags of the head entry
	localparam int CLR_HI  = 0;
	localparam int CLR_FS  = 1;
	localparam int CLR_ISR = 2;
	localparam int CLR_RES = 3;

	// Values after reset
	localparam logic [15:0] RST_TX_LEN = 16'h0000;
	localparam logic [7:0]  RST_INT_EN = 8'h00;
	localparam logic [4:0]  RST_TX_THR = 5'h00;

	// Transmit packet phase
	typedef enum logic [1:0]
	{
		TX_IDLE  = 2'b00,
		TX_FILL  = 2'b01,
		TX_DRAIN = 2'b10
	} hsc_tx_e;
endpackage : hsc_pkg

// ---- rtl/hsc_stack.sv ----
// Four-entry first-in first-out queue of received packet status
`timescale 1ns/1ps
module hsc_stack #(
	parameter int W     = 28,
	parameter int DEPTH = 4
) (
	// Clock and reset
	input  wire logic                       ref_clk,
	input  wire logic                       rst_n,
	input  wire logic                       clk_en,
	// Queue ports
	input  wire logic                       push,
	input  wire logic                       pop,
	input  wire logic [W-1:0]               din,
	output logic      [W-1:0]               dout,
	output logic      [$clog2(DEPTH+1)-1:0] count,
	output logic                            full,
	output logic                            empty
);
	localparam int PW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH+1);

	logic [W-1:0]  mem_q [DEPTH];
	logic [PW-1:0] wr_q;
	logic [PW-1:0] rd_q;
	logic [CW-1:0] cnt_q;
	logic          do_push;
	logic          do_pop;

	// Push refused when full, pop when empty
	assign do_push = push && (cnt_q != CW'(DEPTH));
	assign do_pop  = pop && (cnt_q != '0);
	assign dout    = mem_q[rd_q];
	assign count   = cnt_q;
	assign full    = (cnt_q == CW'(DEPTH));
	assign empty   = (cnt_q == '0);

	// Entry storage
	always_ff @(posedge ref_clk)
	begin
		if (clk_en && do_push)
			mem_q[wr_q] <= din;
	end

	// Pointers and level
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wr_q  <= '0;
			rd_q  <= '0;
			cnt_q <= '0;
		end
		else if (clk_en)
		begin
			if (do_push)
				wr_q <= (wr_q == PW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
			if (do_pop)
				rd_q <= (rd_q == PW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
			cnt_q <= cnt_q + CW'(do_push) - CW'(do_pop);
		end
	end
endmodule : hsc_stack

// ---- tb/hsc_assertions.sv ----
// Port checks for the status stack and transmit pacing block
`timescale 1ns/1ps
module hsc_assertions (
	// Watched ports
	input wire logic ref_clk, rst_n, psel, penable, pready, pslverr, rx_pkt_end,
	input wire logic rx_blocked, rx_hunt, rx_dma_raw, rx_dma_request,
	input wire logic tx_fifo_wr, tx_fifo_full, tx_fifo_empty, tx_dma_request, tx_start_flag, tx_last_to_shift
);
	logic open_q;
	// Packet open from its first FIFO write until its last byte shifts
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			open_q <= 1'b0;
		else
			open_q <= (open_q || tx_fifo_wr) && !tx_last_to_shift;
	end
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	property p_ans; psel && penable |-> ##[0:15] pready; endproperty
	a_ans: assert property (p_ans) else $error("bus answer late");
	property p_err; pslverr |-> pready; endproperty
	a_err: assert property (p_err) else $error("error without ready");
	property p_full; tx_fifo_full [*2] |-> !tx_dma_request; endproperty
	a_full: assert property (p_full) else $error("request while full");
	property p_blk; $rose(rx_blocked) |-> $past(rx_pkt_end) || $past(rx_pkt_end, 2); endproperty
	a_blk: assert property (p_blk) else $error("block without packet end");
	property p_hold; rx_blocked && !psel |=> rx_blocked; endproperty
	a_hold: assert property (p_hold) else $error("block released unread");
	property p_hunt; $fell(rx_blocked) |-> ##[0:2] rx_hunt; endproperty
	a_hunt: assert property (p_hunt) else $error("no hunt after release");
	property p_rxq; !rx_dma_raw [*2] |-> !rx_dma_request; endproperty
	a_rxq: assert property (p_rxq) else $error("receive request unprompted");
	property p_flag; tx_fifo_wr && !open_q |=> tx_start_flag; endproperty
	a_flag: assert property (p_flag) else $error("no opening flag");
endmodule : hsc_assertions
bind hsc_top hsc_assertions u_chk (.*);

// ---- tb/hsc_dma_model.sv ----
// Transmit DMA and FIFO stand-in
`timescale 1ns/1ps
module hsc_dma_model (
	// Clock, reset, request and last-byte mark in; FIFO state out
	input wire logic   ref_clk, rst_n, req, mark,
	output logic       wr, full, empty, last_shift,
	output logic [4:0] level
);
	logic [1:0] div_q;
	logic       pend_q;
	logic       drain;
	assign drain = div_q == 2'h0 && level != 5'h00;
	// Writes every other cycle on request, drains a byte per four cycles
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wr <= 1'b0;
			level <= 5'h00;
			div_q <= 2'h0;
			pend_q <= 1'b0;
			last_shift <= 1'b0;
		end
		else
		begin
			div_q <= div_q + 2'h1;
			wr <= req && !wr && !full;
			pend_q <= (pend_q || mark) && !(drain && level == 5'h01);
			last_shift <= (pend_q || mark) && drain && level == 5'h01;
			level <= level + {4'h0, wr} - {4'h0, drain};
		end
	end
	assign full = level >= 5'h10;
	assign empty = level == 5'h00;
endmodule : hsc_dma_model

// ---- tb/hsc_top_bench.sv ----
// Bench for the status stack and transmit pacing block
`timescale 1ns/1ps
module hsc_top_bench;
	logic ref_clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic rx_pkt_end = 0, rx_last = 0, rx_blocked, rx_hunt, rx_dma_request;
	logic [15:0] rx_byte_cnt = 16'h0;
	logic [4:0] rx_frame_err = 5'h00, lvl;
	logic wr, full, empty, lsh, tx_dma_request, sf, lbm, irq;
	int num_errors = 0, check_count = 0, cyc = 0, nwr = 0;
	hsc_top dut (.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(1'b1), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .rx_pkt_end(rx_pkt_end), .rx_overrun(1'b0), .rx_byte_cnt(rx_byte_cnt),
		.rx_frame_err(rx_frame_err), .rx_addr_id(3'h1), .rx_residue(3'h2), .rx_last_byte_out(rx_last),
		.rx_dma_raw(1'b0), .rx_blocked(rx_blocked), .rx_hunt(rx_hunt), .rx_dma_request(rx_dma_request),
		.tx_fifo_wr(wr), .tx_fifo_level(lvl), .tx_fifo_full(full), .tx_fifo_empty(empty),
		.tx_last_to_shift(lsh), .tx_dma_request(tx_dma_request), .tx_start_flag(sf),
		.tx_last_byte_mark(lbm), .link_ctrl_irq_out(irq));
	hsc_dma_model u_dma (.ref_clk(ref_clk), .rst_n(rst_n), .req(tx_dma_request), .wr(wr),
		.mark(lbm), .full(full), .empty(empty), .last_shift(lsh), .level(lvl));
	initial forever #5 ref_clk = ~ref_clk;
	// Cycle count, write tally and hang limit
	always @(posedge ref_clk)
	begin
		cyc++;
		nwr += wr;
		if (cyc == 20000)
		begin
			num_errors++;
			summarize();
		end
	end
	task summarize;
		$display("checks %0d mismatches %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : summarize
	task chk(input string n, input logic [31:0] s, e);
		check_count++;
		if (s !== e)
		begin
			num_errors++;
			$display("CHECK FAILED %s exp %h got %h", n, e, s);
		end
	endtask : chk
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		{psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
		@(posedge ref_clk);
		penable <= 1'b1;
		do @(negedge ref_clk); while (pready !== 1'b1);
		rd = prdata;
		@(posedge ref_clk);
		{psel, penable} <= 2'b00;
	endtask : apb
	task rx_scenario;
		apb(1'b1, hsc_pkg::OFF_INT_EN, 32'h08);
		for (int i = 0; i < 4; i++)
		begin
			@(posedge ref_clk);
			{rx_pkt_end, rx_byte_cnt, rx_frame_err} <= {1'b1, 16'(11 + i), (i == 1) ? 5'h04 : 5'h00};
			@(posedge ref_clk);
			{rx_pkt_end, rx_last} <= 2'b01;
			@(posedge ref_clk);
			rx_last <= 1'b0;
		end
		repeat (3) @(posedge ref_clk);
		chk("blocked", {31'h0, rx_blocked}, 32'h1);
		chk("irq", {31'h0, irq}, 32'h1);
		for (int i = 0; i < 4; i++)
		begin
			apb(1'b0, hsc_pkg::OFF_INT_SRC, 32'h0);
			chk("valid", {31'h0, rd[hsc_pkg::ISR_VALID_RX]}, {31'h0, i != 1});
			chk("fserr", {31'h0, rd[hsc_pkg::ISR_FS_ERR]}, {31'h0, i == 1});
			chk("addr", {29'h0, rd[2:0]}, 32'h1);
			apb(1'b0, hsc_pkg::OFF_INT_SRC, 32'h0);
			chk("cleared", {31'h0, rd[hsc_pkg::ISR_VALID_RX]}, 32'h0);
			chk("noaddr", {29'h0, rd[2:0]}, {29'h0, hsc_pkg::ADR_NO_PACKET});
			apb(1'b0, hsc_pkg::OFF_FRAME_ST, 32'h0);
			chk("frame", {26'h0, rd[5:0]}, (i == 1) ? 32'h4 : 32'h0);
			apb(1'b0, hsc_pkg::OFF_RESIDUE, 32'h0);
			chk("residue", {29'h0, rd[2:0]}, 32'h2);
			apb(1'b0, hsc_pkg::OFF_RBC_HI, 32'h0);
			chk("counthi", {24'h0, rd[7:0]}, 32'h0);
			apb(1'b0, hsc_pkg::OFF_RBC_LO, 32'h0);
			chk("count", {24'h0, rd[7:0]}, 32'(11 + i));
			@(negedge ref_clk);
			chk("unblocked", {31'h0, rx_blocked}, 32'h0);
		end
	endtask : rx_scenario
	task tx_scenario;
		apb(1'b1, hsc_pkg::OFF_TX_THR, 32'h2);
		apb(1'b1, hsc_pkg::OFF_TX_LEN, 32'h30);
		repeat (3) @(negedge ref_clk);
		chk("req", {31'h0, tx_dma_request}, 32'h1);
		while (lsh !== 1'b1) @(negedge ref_clk);
		chk("writes", 32'(nwr), 32'h30);
		repeat (3) @(negedge ref_clk);
		chk("reload", {31'h0, tx_dma_request}, 32'h1);
		apb(1'b0, hsc_pkg::OFF_INT_SRC, 32'h0);
		chk("sent", {31'h0, rd[hsc_pkg::ISR_VALID_TX]}, 32'h1);
		apb(1'b1, hsc_pkg::OFF_TX_LEN, 32'h8);
		@(negedge ref_clk);
		while (lsh !== 1'b1) @(negedge ref_clk);
		chk("held", 32'(nwr), 32'h60);
		@(negedge ref_clk);
		while (lsh !== 1'b1) @(negedge ref_clk);
		chk("newlen", 32'(nwr), 32'h68);
	endtask : tx_scenario
	initial
	begin
		repeat (3) @(posedge ref_clk);
		rst_n <= 1'b1;
		rx_scenario();
		tx_scenario();
		summarize();
	end
endmodule : hsc_top_bench
